/* File: ita_target.sv */
`timescale 1ns/1ps
// Behaviour
// - write control byte: code, block, rw zero
// - ack matching control, then word address
// - pointer is block bits over word address
// - ack word address, then one data byte
// - ack data byte, master then stops
// - data committed on its eighth bit, before its acknowledge
// - random read first loads pointer by write
// - repeated start keeps pointer, drops write
// - read control acked, eight bits shifted out
// - switch a disable at 0xF4, reset 0
// - switch b disable bit, reset 0
// - led1 pwm at 0xC0, reset 0x65
// - led2 pwm at 0xC1, reset 0x65
// - led3 pwm at 0xC2, reset 0x65
// - lock options block reads or writes
// - control code comes from configuration input
// - word address follows except current read
module ita_target
  import ita_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  ita_bus_if.target       bus,
  input  wire logic [3:0] ctrl_code,
  input  wire ita_lock_t  lock_mode,
  input  wire logic       lock_write_all,
  output logic [7:0]      led1_pwm_setting,
  output logic [7:0]      led2_pwm_setting,
  output logic [7:0]      led3_pwm_setting,
  output logic            switch_a_disable,
  output logic            switch_b_disable
);
  typedef enum logic [2:0] {
    ITA_IDLE, ITA_CTRL, ITA_WADDR, ITA_WDATA, ITA_RDATA, ITA_RACK, ITA_SKIP
  } ita_state_t;

  logic [2:0]  scl_sync_ff;
  logic [2:0]  sda_sync_ff;
  ita_state_t  state_ff;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [10:0] ptr_ff;
  logic        ack_ff;
  logic        sda_oe_ff;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [7:0]  rx_byte;
  logic        wr_ok;
  logic        rd_ok;
  logic [7:0]  rd_data;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[1:0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[1:0], bus.sda};
    end
  end

  // edges judged only on stages 1 and 2
  assign scl_rise  = scl_sync_ff[1] && !scl_sync_ff[2];
  assign scl_fall  = !scl_sync_ff[1] && scl_sync_ff[2];
  assign start_det = scl_sync_ff[1] && scl_sync_ff[2] && !sda_sync_ff[1] && sda_sync_ff[2];
  assign stop_det  = scl_sync_ff[1] && scl_sync_ff[2] && sda_sync_ff[1] && !sda_sync_ff[2];
  assign rx_byte   = {shift_ff[6:0], sda_sync_ff[2]};

  // lockable range ends below the pwm block; only write-all covers every byte
  always_comb
  begin
    wr_ok = 1'b1;
    rd_ok = 1'b1;
    if (lock_write_all)
      wr_ok = 1'b0;
    if (ptr_ff < LOCK_LIMIT)
    begin
      if (lock_mode == ITA_LOCK_WRITE || lock_mode == ITA_LOCK_BOTH)
        wr_ok = 1'b0;
      if (lock_mode == ITA_LOCK_READ || lock_mode == ITA_LOCK_BOTH)
        rd_ok = 1'b0;
    end
  end

  always_comb
  begin
    rd_data = 8'h00;
    unique case (ptr_ff)
      OFS_LED1_PWM: rd_data = led1_pwm_setting;
      OFS_LED2_PWM: rd_data = led2_pwm_setting;
      OFS_LED3_PWM: rd_data = led3_pwm_setting;
      OFS_SWITCH:   rd_data = {6'h00, switch_b_disable, switch_a_disable};
      default:      rd_data = 8'h00;
    endcase
    if (!rd_ok)
      rd_data = 8'hFF;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= ITA_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      ptr_ff     <= 11'h000;
      ack_ff     <= 1'b0;
    end
    else if (start_det)
    begin
      state_ff   <= ITA_CTRL;
      bit_cnt_ff <= 4'h0;
      ack_ff     <= 1'b0;
    end
    else if (stop_det)
    begin
      state_ff   <= ITA_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_ff     <= 1'b0;
    end
    else if (scl_fall && bit_cnt_ff == 4'h9)
    begin
      // ninth clock over: next byte starts
      ack_ff     <= 1'b0;
      bit_cnt_ff <= 4'h0;
      if (state_ff == ITA_RDATA)
        shift_ff <= rd_data;
    end
    else if (scl_rise && bit_cnt_ff == 4'h8)
    begin
      // ninth clock is the ack slot, never a data bit
      bit_cnt_ff <= 4'h9;
      // master ack or nack ends the read alike (sequential not served)
      if (state_ff == ITA_RACK)
        state_ff <= ITA_SKIP;
    end
    else if (scl_rise && state_ff != ITA_IDLE && state_ff != ITA_SKIP && !ack_ff)
    begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (state_ff == ITA_RDATA)
        shift_ff <= {shift_ff[6:0], 1'b1};
      else
        shift_ff <= rx_byte;
      if (bit_cnt_ff == 4'h7)
      begin
        unique case (state_ff)
          ITA_CTRL:
          begin
            if (rx_byte[7:4] == ctrl_code)
            begin
              ack_ff <= 1'b1;
              if (rx_byte[0])
                state_ff <= ITA_RDATA;
              else
              begin
                ptr_ff[10:8] <= rx_byte[3:1];
                state_ff     <= ITA_WADDR;
              end
            end
            else
              state_ff <= ITA_SKIP;
          end
          ITA_WADDR:
          begin
            ptr_ff[7:0] <= rx_byte;
            ack_ff      <= 1'b1;
            state_ff    <= ITA_WDATA;
          end
          ITA_WDATA:
          begin
            ack_ff   <= 1'b1;
            state_ff <= ITA_SKIP;
          end
          ITA_RDATA:
            state_ff <= ITA_RACK;
          default:
            state_ff <= ITA_SKIP;
        endcase
      end
    end
  end

  // committed on the rising clock that ends the data byte; its ack is driven from the next scl fall
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      led1_pwm_setting <= RST_LED_PWM;
      led2_pwm_setting <= RST_LED_PWM;
      led3_pwm_setting <= RST_LED_PWM;
      switch_a_disable <= RST_SWITCH;
      switch_b_disable <= RST_SWITCH;
    end
    else if (scl_rise && state_ff == ITA_WDATA && !ack_ff && bit_cnt_ff == 4'h7 && wr_ok)
    begin
      unique case (ptr_ff)
        OFS_LED1_PWM: led1_pwm_setting <= rx_byte;
        OFS_LED2_PWM: led2_pwm_setting <= rx_byte;
        OFS_LED3_PWM: led3_pwm_setting <= rx_byte;
        OFS_SWITCH:
        begin
          switch_a_disable <= rx_byte[POS_SWITCH_A];
          switch_b_disable <= rx_byte[POS_SWITCH_B];
        end
        default: ;
      endcase
    end
  end

  // sda changes only after scl falls, keeping data stable while high
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sda_oe_ff     <= 1'b0;
      bus.sda_t_out <= 1'b0;
    end
    else if (start_det || stop_det)
      sda_oe_ff <= 1'b0;
    else if (scl_fall)
    begin
      if (ack_ff && bit_cnt_ff == 4'h8)
        sda_oe_ff <= 1'b1;
      else if (bit_cnt_ff == 4'h9 && state_ff == ITA_RDATA)
        sda_oe_ff <= !rd_data[7];
      else if (state_ff == ITA_RDATA && bit_cnt_ff < 4'h8)
        sda_oe_ff <= !shift_ff[7];
      else
        sda_oe_ff <= 1'b0;
    end
  end

  always_comb
  begin
    bus.sda_t_oe = sda_oe_ff;
  end
endmodule

/* File: ita_pkg.sv */
package ita_pkg;
  localparam logic [3:0]  CTRL_CODE_RST     = 4'h5;
  localparam logic [10:0] OFS_LED1_PWM      = 11'h0C0;
  localparam logic [10:0] OFS_LED2_PWM      = 11'h0C1;
  localparam logic [10:0] OFS_LED3_PWM      = 11'h0C2;
  localparam logic [10:0] OFS_SWITCH        = 11'h0F4;
  localparam int          POS_SWITCH_A      = 0;
  localparam int          POS_SWITCH_B      = 1;
  localparam logic [7:0]  RST_LED_PWM       = 8'h65;
  localparam logic        RST_SWITCH        = 1'h0;
  localparam logic [10:0] LOCK_LIMIT        = 11'h0C0;
  localparam int          SCL_HALF_CYCLES   = 25;
  typedef enum logic [1:0] {
    ITA_LOCK_NONE,
    ITA_LOCK_READ,
    ITA_LOCK_WRITE,
    ITA_LOCK_BOTH
  } ita_lock_t;
endpackage

/* File: ita_bus_if.sv */
`timescale 1ns/1ps
interface ita_bus_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_t_out;
  logic sda_t_oe;
  logic sda;
  // open drain wire: low wins, pulled high otherwise
  assign sda = !((sda_m_oe && !sda_m_out) || (sda_t_oe && !sda_t_out));
  modport target (input scl, input sda, output sda_t_out, output sda_t_oe);
  modport master (output scl, input sda, output sda_m_out, output sda_m_oe);
endinterface

/* File: ita_master.sv */
`timescale 1ns/1ps
module ita_master
  import ita_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  ita_bus_if.master        bus,
  input  wire logic        req,
  input  wire logic        req_read,
  input  wire logic [3:0]  req_code,
  input  wire logic [10:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             busy,
  output logic             done,
  output logic             nack,
  output logic [7:0]       rdata
);
  typedef enum logic [2:0] {
    ITM_IDLE, ITM_START, ITM_BIT, ITM_STOP, ITM_END
  } ita_mstate_t;

  ita_mstate_t state_ff;
  logic [5:0]  half_ff;
  logic [1:0]  phase_ff;
  logic [3:0]  bit_ff;
  logic [2:0]  byte_ff;
  logic [8:0]  shift_ff;
  logic        rd_ff;
  logic [10:0] addr_ff;
  logic [3:0]  code_ff;
  logic [7:0]  wdata_ff;
  logic [1:0]  sda_sync_ff;
  logic        tick;
  logic [8:0]  nxt_frame;
  logic        last_byte;
  logic [2:0]  frame_sel;

  assign tick = half_ff == 6'(SCL_HALF_CYCLES - 1);

  // the ack edge loads the following byte, a start loads its own
  assign frame_sel = (state_ff == ITM_START) ? byte_ff : byte_ff + 3'h1;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sda_sync_ff <= 2'h3;
    else
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
  end

  // byte plan: ctrl w, word addr, then data or restart + ctrl r + read
  always_comb
  begin
    nxt_frame = 9'h1FF;
    unique case (frame_sel)
      3'h0: nxt_frame = {code_ff, addr_ff[10:8], 1'b0, 1'b1};
      3'h1: nxt_frame = {addr_ff[7:0], 1'b1};
      3'h2: nxt_frame = rd_ff ? {code_ff, addr_ff[10:8], 1'b1, 1'b1}
                              : {wdata_ff, 1'b1};
      default: nxt_frame = 9'h1FF; // read byte, master nack
    endcase
  end
  assign last_byte = rd_ff ? byte_ff == 3'h3 : byte_ff == 3'h2;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff      <= ITM_IDLE;
      half_ff       <= 6'h00;
      phase_ff      <= 2'h0;
      bit_ff        <= 4'h0;
      byte_ff       <= 3'h0;
      shift_ff      <= 9'h1FF;
      rd_ff         <= 1'b0;
      addr_ff       <= 11'h000;
      code_ff       <= 4'h0;
      wdata_ff      <= 8'h00;
      bus.scl       <= 1'b1;
      bus.sda_m_out <= 1'b0;
      bus.sda_m_oe  <= 1'b0;
      busy          <= 1'b0;
      done          <= 1'b0;
      nack          <= 1'b0;
      rdata         <= 8'h00;
    end
    else
    begin
      done    <= 1'b0;
      half_ff <= tick ? 6'h00 : half_ff + 6'h01;
      unique case (state_ff)
        ITM_IDLE:
          if (req)
          begin
            rd_ff    <= req_read;
            addr_ff  <= req_addr;
            code_ff  <= req_code;
            wdata_ff <= req_wdata;
            byte_ff  <= 3'h0;
            busy     <= 1'b1;
            nack     <= 1'b0;
            phase_ff <= 2'h0;
            state_ff <= ITM_START;
          end
        ITM_START:
          if (tick)
          begin
            phase_ff <= phase_ff + 2'h1;
            unique case (phase_ff)
              2'h0:
              begin
                bus.scl      <= 1'b1;
                bus.sda_m_oe <= 1'b0;
              end
              2'h1: bus.sda_m_oe <= 1'b1; // falling sda while scl high
              2'h2: bus.scl <= 1'b0;
              default:
              begin
                shift_ff <= nxt_frame;
                bit_ff   <= 4'h0;
                phase_ff <= 2'h0;
                state_ff <= ITM_BIT;
              end
            endcase
          end
        ITM_BIT:
          if (tick)
          begin
            phase_ff <= phase_ff + 2'h1;
            if (phase_ff == 2'h0)
              bus.sda_m_oe <= !shift_ff[8];
            else if (phase_ff == 2'h1)
              bus.scl <= 1'b1;
            else
            begin
              bus.scl  <= 1'b0;
              phase_ff <= 2'h0;
              shift_ff <= {shift_ff[7:0], 1'b1};
              bit_ff   <= bit_ff + 4'h1;
              if (byte_ff == 3'h3 && bit_ff < 4'h8)
                rdata <= {rdata[6:0], sda_sync_ff[1]};
              if (bit_ff == 4'h8)
              begin
                if (sda_sync_ff[1] && !(byte_ff == 3'h3))
                begin
                  nack     <= 1'b1;
                  state_ff <= ITM_STOP;
                end
                else if (last_byte)
                  state_ff <= ITM_STOP;
                else if (rd_ff && byte_ff == 3'h1)
                begin
                  byte_ff  <= 3'h2;
                  state_ff <= ITM_START; // repeated start
                end
                else
                begin
                  byte_ff  <= byte_ff + 3'h1;
                  shift_ff <= nxt_frame;
                  bit_ff   <= 4'h0;
                end
              end
            end
            if (phase_ff == 2'h2 && bit_ff == 4'h8 && byte_ff == 3'h2 && rd_ff)
              byte_ff <= 3'h3;
          end
        ITM_STOP:
          if (tick)
          begin
            phase_ff <= phase_ff + 2'h1;
            unique case (phase_ff)
              2'h0: bus.sda_m_oe <= 1'b1;
              2'h1: bus.scl <= 1'b1;
              2'h2: bus.sda_m_oe <= 1'b0; // rising sda while scl high
              default: state_ff <= ITM_END;
            endcase
          end
        ITM_END:
        begin
          busy     <= 1'b0;
          done     <= 1'b1;
          state_ff <= ITM_IDLE;
        end
        default: state_ff <= ITM_IDLE;
      endcase
    end
  end
endmodule

/* File: ita_bus_monitor.sv */
`timescale 1ns/1ps
module ita_bus_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_t_out,
  input wire logic sda_t_oe,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       first_ff;
  logic       rd_ff;
  logic [3:0] bit_ff;
  wire        start = scl_q && scl && sda_q && !sda;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // bit position within a byte, first byte flag and read phase, rebuilt from the wire
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q    <= 1'h1;
      sda_q    <= 1'h1;
      bit_ff   <= 4'h0;
      first_ff <= 1'h0;
      rd_ff    <= 1'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start)
      begin
        bit_ff   <= 4'h0;
        first_ff <= 1'h1;
        rd_ff    <= 1'h0;
      end
      else if (scl && !scl_q)
      begin
        bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
        if (bit_ff == 4'h8)
          first_ff <= 1'h0;
        if (bit_ff == 4'h7 && first_ff)
          rd_ff <= sda;
      end
    end
  end

  AST_IDLE_AFTER_RST: assert property ($past(rst) |-> scl && sda)
    else $error("bus not idle after reset");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl[*8])
    else $error("scl low phase too short");
  AST_TGT_STILL_HIGH: assert property (scl && $past(scl) |->
    $stable(sda_t_oe) && (!sda_t_oe || $stable(sda_t_out)))
    else $error("target changed sda while scl high");
  AST_EDGES_BY_MASTER: assert property (scl && $past(scl) && $changed(sda) |-> !sda_t_oe)
    else $error("start or stop edge while target drives");
  AST_ACK_SLOT: assert property ($rose(scl) && sda_t_oe && !rd_ff |-> bit_ff == 4'h8)
    else $error("target drives outside the ninth bit");
  AST_ACK_PULLS_LOW: assert property (sda_t_oe && !rd_ff |-> !sda)
    else $error("target ack does not pull sda low");
  AST_ACK_RELEASED: assert property ($fell(scl) && bit_ff == 4'h0 && !rd_ff
    |-> ##[0:12] !sda_t_oe)
    else $error("target holds sda after ack");
endmodule

/* File: tb_i2c_target_reg_access.sv */
`timescale 1ns/1ps
module tb_i2c_target_reg_access
  import ita_pkg::*;
  ;
  logic        ref_clk;
  logic        rst;
  logic        req;
  logic        req_read;
  logic        lock_write_all;
  logic        busy;
  logic        done;
  logic        nack;
  logic        sw_a;
  logic        sw_b;
  logic [3:0]  ctrl_code;
  logic [3:0]  use_code;
  logic [10:0] req_addr;
  logic [7:0]  req_wdata;
  logic [7:0]  rdata;
  logic [7:0]  led1;
  logic [7:0]  led2;
  logic [7:0]  led3;
  ita_lock_t   lock_mode;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  ita_bus_if bus_if ();
  ita_target u_ita_target (.ref_clk, .rst, .bus(bus_if.target), .ctrl_code, .lock_mode,
    .lock_write_all, .led1_pwm_setting(led1), .led2_pwm_setting(led2),
    .led3_pwm_setting(led3), .switch_a_disable(sw_a), .switch_b_disable(sw_b));
  ita_master u_ita_master (.ref_clk, .rst, .bus(bus_if.master), .req, .req_read,
    .req_code(use_code), .req_addr, .req_wdata, .busy, .done, .nack, .rdata);
  ita_bus_monitor u_ita_bus_monitor (.ref_clk, .rst, .scl(bus_if.scl),
    .sda_m_out(bus_if.sda_m_out),
    .sda_m_oe(bus_if.sda_m_oe), .sda_t_out(bus_if.sda_t_out),
    .sda_t_oe(bus_if.sda_t_oe), .sda(bus_if.sda));

  initial
  begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one whole transfer; the master owns all bus timing
  task automatic xfer(input logic rd, input logic [10:0] a, input logic [7:0] d);
    int n;
    @(negedge ref_clk);
    req = 1'h1;
    req_read = rd;
    req_addr = a;
    req_wdata = d;
    @(negedge ref_clk);
    req = 1'h0;
    n = 0;
    while (done !== 1'h1 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("done", {7'h0, done}, 8'h01);
  endtask

  task automatic t_reset;
    check("led1 rst", led1, RST_LED_PWM);
    check("led2 rst", led2, RST_LED_PWM);
    check("led3 rst", led3, RST_LED_PWM);
    check("sw_a rst", {7'h0, sw_a}, {7'h0, RST_SWITCH});
    check("sw_b rst", {7'h0, sw_b}, {7'h0, RST_SWITCH});
    $display("t_reset end");
  endtask

  task automatic t_writes;
    xfer(1'h0, OFS_LED1_PWM, 8'hA1);
    xfer(1'h0, OFS_LED2_PWM, 8'hB2);
    xfer(1'h0, OFS_LED3_PWM, 8'h00);
    check("led1", led1, 8'hA1);
    check("led2", led2, 8'hB2);
    check("led3", led3, 8'h00);
    xfer(1'h0, OFS_SWITCH, 8'h02);
    check("sw_a", {7'h0, sw_a}, 8'h00);
    check("sw_b", {7'h0, sw_b}, 8'h01);
    xfer(1'h0, OFS_SWITCH, 8'h01);
    check("sw_a", {7'h0, sw_a}, 8'h01);
    check("sw_b", {7'h0, sw_b}, 8'h00);
    xfer(1'h1, OFS_LED2_PWM, 8'h00);
    check("read led2", rdata, 8'hB2);
    check("read nack", {7'h0, nack}, 8'h00);
    $display("t_writes end");
  endtask

  // the store must land while the transfer is still running, not at the stop
  task automatic t_commit;
    fork
      xfer(1'h0, OFS_LED1_PWM, 8'h3C);
      begin
        @(negedge ref_clk);
        @(negedge ref_clk);
        while (led1 !== 8'h3C && busy === 1'h1)
          @(negedge ref_clk);
        check("busy at store", {7'h0, busy}, 8'h01);
      end
    join
    check("led1", led1, 8'h3C);
    $display("t_commit end");
  endtask

  task automatic t_code;
    use_code = 4'hA;
    xfer(1'h0, OFS_LED1_PWM, 8'h77);
    check("nack bad code", {7'h0, nack}, 8'h01);
    check("led1 kept", led1, 8'h3C);
    ctrl_code = 4'hA;
    xfer(1'h0, OFS_LED1_PWM, 8'h77);
    check("nack new code", {7'h0, nack}, 8'h00);
    check("led1 new code", led1, 8'h77);
    ctrl_code = CTRL_CODE_RST;
    use_code = CTRL_CODE_RST;
    $display("t_code end");
  endtask

  // only bytes below the pwm block sit in the read/write lock range
  task automatic t_lock;
    lock_mode = ITA_LOCK_WRITE;
    xfer(1'h0, OFS_LED3_PWM, 8'h55);
    check("led3 above lock", led3, 8'h55);
    lock_mode = ITA_LOCK_READ;
    xfer(1'h1, LOCK_LIMIT - 11'h001, 8'h00);
    check("read locked", rdata, 8'hFF);
    xfer(1'h1, OFS_LED2_PWM, 8'h00);
    check("read above lock", rdata, 8'hB2);
    lock_mode = ITA_LOCK_BOTH;
    xfer(1'h0, OFS_LED1_PWM, 8'h11);
    check("led1 above lock", led1, 8'h11);
    xfer(1'h1, LOCK_LIMIT - 11'h001, 8'h00);
    check("read both", rdata, 8'hFF);
    lock_mode = ITA_LOCK_NONE;
    xfer(1'h1, LOCK_LIMIT - 11'h001, 8'h00);
    check("read unlocked", rdata, 8'h00);
    lock_write_all = 1'h1;
    xfer(1'h0, OFS_SWITCH, 8'h00);
    check("sw_a locked", {7'h0, sw_a}, 8'h01);
    xfer(1'h0, OFS_LED1_PWM, 8'h22);
    check("led1 write all", led1, 8'h11);
    lock_write_all = 1'h0;
    $display("t_lock end");
  endtask

  // block bits set: same word address lands elsewhere
  task automatic t_block;
    xfer(1'h0, 11'h1C1, 8'h99);
    check("led2 other block", led2, 8'hB2);
    xfer(1'h1, 11'h1C1, 8'h00);
    check("read other block", rdata, 8'h00);
    $display("t_block end");
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_errors++;
      conclude;
    end
  end

  initial
  begin
    rst = 1'h1;
    req = 1'h0;
    req_read = 1'h0;
    req_addr = 11'h000;
    req_wdata = 8'h00;
    ctrl_code = CTRL_CODE_RST;
    use_code = CTRL_CODE_RST;
    lock_mode = ITA_LOCK_NONE;
    lock_write_all = 1'h0;
    repeat (3) @(negedge ref_clk);
    rst = 1'h0;
    t_reset;
    t_writes;
    t_commit;
    t_code;
    t_lock;
    t_block;
    conclude;
  end
endmodule
